// File: shared/port_b_pkg.sv
//
// Behaviour
// R1 - Pin analog/digital behaviour follows analog select bit and direction bit together.
// R2 - Software keeps direction at input for every pin used as converter input.
// R3 - Analog pin set as output feeds its own driven level to converter.
// R4 - Pin-level read returns zero where pin is an analog input channel.
// R5 - Pins in digital mode are never presented to the converter.
// R6 - Software waits one instruction cycle between port write and port read.
// R7 - Enabled input pin change raises interrupt request to processor.
// R8 - Change detection works with clocks stopped; no clock needed to catch it.
// R9 - Up to 22 change inputs, each individually enabled.
// R10 - Direction register resets to bits 5..0 set, upper bits clear.
// R11 - Pin-level and holding registers implement bits 5..0, reset to zero.
// R12 - Direction one makes pin input; zero drives pin from holding bit.
// R13 - Holding reads held value, pin-level reads pins, writes to either update holding.
// R14 - Unimplemented bits read zero in direction, holding and pin-level.
// R15 - Analog select bit gates digital input path off in analog mode.
package port_b_pkg;

    // ==========================================================
    // Register map
    localparam logic [15:0] ADDR_DIR_SELECT_B   = 16'h02c6;
    localparam logic [15:0] ADDR_PIN_LEVEL_B    = 16'h02c8;
    localparam logic [15:0] ADDR_OUT_HOLDING_B  = 16'h02cb;
    localparam logic [15:0] ADDR_ANALOG_SEL_CFG = 16'h02a8;
    localparam logic [15:0] ADDR_CHANGE_ENABLE  = 16'h02b0;
    localparam logic [15:0] ADDR_CHANGE_ENABLE_HI = 16'h02b2;

    // ==========================================================
    // Widths and reset values
    localparam int          PORT_BITS          = 6;
    localparam int          CHANGE_INPUTS      = 22;
    localparam logic [15:0] IMPL_MASK_B        = 16'h003f;
    localparam logic [15:0] RST_DIR_SELECT_B   = 16'h003f;
    localparam logic [15:0] RST_OUT_HOLDING_B  = 16'h0000;
    localparam logic [15:0] RST_ANALOG_SEL_CFG = 16'h0000;
    localparam logic [21:0] RST_CHANGE_ENABLE  = 22'h000000;
    localparam logic [15:0] READ_ZERO          = 16'h0000;

    // ==========================================================
    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

endpackage

// File: rtl/port_b_analog_change_notify.sv
// Local design decision: strobed register access.
`timescale 1ns/100ps
module port_b_analog_change_notify #(
    parameter int PORT_BITS     = port_b_pkg::PORT_BITS,
    parameter int CHANGE_INPUTS = port_b_pkg::CHANGE_INPUTS
) (
    input  wire logic                     CORE_CLK_IN,
    input  wire logic                     RESET_IN,
    input  wire logic [15:0]              REG_ADDR_IN,
    input  wire logic [15:0]              REG_WDATA_IN,
    input  wire logic                     REG_WR_IN,
    input  wire logic                     REG_RD_IN,
    output logic      [15:0]              REG_RDATA_OUT,
    input  wire logic [PORT_BITS-1:0]     PIN_IN,
    output logic      [PORT_BITS-1:0]     PIN_OUT,
    output logic      [PORT_BITS-1:0]     PIN_OE_N_OUT,
    output logic      [PORT_BITS-1:0]     ANALOG_ROUTE_OUT,
    output logic      [PORT_BITS-1:0]     ANALOG_OWN_LEVEL_OUT,
    input  wire logic [CHANGE_INPUTS-1:0] CHANGE_PIN_IN,
    output logic                          CHANGE_IRQ_OUT
);

    // ==========================================================
    // Usage notes
    // Pin levels pass a two-flop synchroniser, so a pin-level read
    // shows a pad change two cycles late; software leaves a cycle
    // between a port write and a read of the same port.
    // Pin-level bits of analog-selected pins always read zero, even
    // with the direction bit at output.
    // The change request is a level, not a sticky flag: it drops
    // once the synchronised inputs have caught up with the pins.
    // While the core clock is stopped the raw pin is compared with
    // the last sampled state, so a change still raises the request.

    // ==========================================================
    // Decode helpers
    // Full-word match only: partial decoding would alias the port
    // registers onto neighbouring peripherals.
    function automatic logic addr_hit(
        input logic [15:0] addr,
        input logic [15:0] reg_addr
    );
        return addr == reg_addr;
    endfunction

    // Port-sized field in the low bits of a bus word, upper bits zero
    function automatic logic [15:0] widen_port(
        input logic [PORT_BITS-1:0] field
    );
        logic [15:0] word;
        word                = port_b_pkg::READ_ZERO;
        word[PORT_BITS-1:0] = field;
        return word;
    endfunction

    // ==========================================================
    // Bus decode
    port_b_pkg::reg_req_s req;
    assign req = '{REG_ADDR_IN, REG_WDATA_IN, REG_WR_IN, REG_RD_IN};

    wire        sel_dir  = addr_hit(req.addr, port_b_pkg::ADDR_DIR_SELECT_B);
    wire        sel_pin  = addr_hit(req.addr, port_b_pkg::ADDR_PIN_LEVEL_B);
    wire        sel_hold = addr_hit(req.addr, port_b_pkg::ADDR_OUT_HOLDING_B);
    wire        sel_ana  = addr_hit(req.addr, port_b_pkg::ADDR_ANALOG_SEL_CFG);
    wire        sel_enl  = addr_hit(req.addr, port_b_pkg::ADDR_CHANGE_ENABLE);
    wire        sel_enh  = addr_hit(req.addr, port_b_pkg::ADDR_CHANGE_ENABLE_HI);
    wire [15:0] wd       = req.wdata;

    // Write enables; the pin-level address writes the holding register
    wire wr_dir  = req.wr & sel_dir;
    wire wr_hold = req.wr & (sel_hold | sel_pin); // R13
    wire wr_ana  = req.wr & sel_ana;
    wire wr_enl  = req.wr & sel_enl;
    wire wr_enh  = req.wr & sel_enh;
    wire wr_en   = wr_enl | wr_enh;

    // ==========================================================
    // Register state
    logic [PORT_BITS-1:0]     dir_select_b_ff;
    logic [PORT_BITS-1:0]     out_holding_b_ff;
    logic [PORT_BITS-1:0]     analog_select_cfg_ff;
    logic [CHANGE_INPUTS-1:0] change_enable_ff;
    logic [15:0]              rdata_ff;
    logic [PORT_BITS-1:0]     pin_meta_ff;
    logic [PORT_BITS-1:0]     pin_sync_ff;
    logic [CHANGE_INPUTS-1:0] chg_meta_ff;
    logic [CHANGE_INPUTS-1:0] chg_sync_ff;
    logic [CHANGE_INPUTS-1:0] chg_prev_ff;
    logic                     irq_ff;

    // Enable bits 15..0 sit in the low word, the rest in the high word
    wire [CHANGE_INPUTS-1:0] enable_lo_word =
        {change_enable_ff[CHANGE_INPUTS-1:16], wd};
    wire [CHANGE_INPUTS-1:0] enable_hi_word =
        {wd[CHANGE_INPUTS-17:0], change_enable_ff[15:0]};
    wire [CHANGE_INPUTS-1:0] nxt_change_enable =
        wr_enl ? enable_lo_word : enable_hi_word;

    // ==========================================================
    // Direction register
    // All pins come out of reset as inputs so nothing is driven
    // before software has set up the port.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            dir_select_b_ff <= port_b_pkg::RST_DIR_SELECT_B[PORT_BITS-1:0]; // R10
        end else if (wr_dir) begin
            dir_select_b_ff <= wd[PORT_BITS-1:0]; // R14
        end
    end

    // ==========================================================
    // Output holding register
    // Holds the drive level whatever the direction, so a pin turned
    // to output starts from a known level.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            out_holding_b_ff <= port_b_pkg::RST_OUT_HOLDING_B[PORT_BITS-1:0]; // R11
        end else if (wr_hold) begin
            out_holding_b_ff <= wd[PORT_BITS-1:0]; // R13
        end
    end

    // ==========================================================
    // Analog select register
    // Reset leaves every pin digital.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            analog_select_cfg_ff <= port_b_pkg::RST_ANALOG_SEL_CFG[PORT_BITS-1:0];
        end else if (wr_ana) begin
            analog_select_cfg_ff <= wd[PORT_BITS-1:0]; // R15
        end
    end

    // ==========================================================
    // Change enable register
    // A write to one word leaves the other word untouched.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            change_enable_ff <= port_b_pkg::RST_CHANGE_ENABLE;
        end else if (wr_en) begin
            change_enable_ff <= nxt_change_enable; // R9
        end
    end

    // ==========================================================
    // Pin synchroniser
    // Two flops before any logic; only the second stage is read.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= PIN_IN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // ==========================================================
    // Per-pin pad and analog control
    wire [PORT_BITS-1:0] drive_n;
    wire [PORT_BITS-1:0] drive_level;
    wire [PORT_BITS-1:0] analog_in;
    wire [PORT_BITS-1:0] analog_out;
    wire [PORT_BITS-1:0] digital_in;
    wire [PORT_BITS-1:0] pin_read;

    genvar gp;
    generate
        for (gp = 0; gp < PORT_BITS; gp++) begin : g_pin
            // Direction one releases the pad, zero drives the holding bit
            assign drive_n[gp]     = dir_select_b_ff[gp]; // R12
            assign drive_level[gp] = out_holding_b_ff[gp]; // R12

            // Analog mode with direction input: converter channel
            assign analog_in[gp]  =
                analog_select_cfg_ff[gp] & dir_select_b_ff[gp]; // R1
            // Analog mode with direction output: converter sees own level
            assign analog_out[gp] =
                analog_select_cfg_ff[gp] & ~dir_select_b_ff[gp]; // R3

            // Input buffer gated off while analog mode is selected
            assign digital_in[gp] =
                pin_sync_ff[gp] & ~analog_select_cfg_ff[gp]; // R15
            // Analog input channels read as zero
            assign pin_read[gp]   = digital_in[gp] & ~analog_in[gp]; // R4
        end
    endgenerate

    // ==========================================================
    // Pad and converter outputs
    assign PIN_OUT              = drive_level; // R12
    assign PIN_OE_N_OUT         = drive_n; // R12
    // Only analog-selected pins reach the converter
    assign ANALOG_ROUTE_OUT     = analog_select_cfg_ff; // R5
    assign ANALOG_OWN_LEVEL_OUT = analog_out & out_holding_b_ff; // R3

    // ==========================================================
    // Read data, one cycle after the strobe
    // Unmapped addresses and unimplemented bits read as zero.
    wire [15:0] rd_mux;
    assign rd_mux =
        sel_dir  ? widen_port(dir_select_b_ff) :
        sel_pin  ? widen_port(pin_read) :
        sel_hold ? widen_port(out_holding_b_ff) :
        sel_ana  ? widen_port(analog_select_cfg_ff) :
        sel_enl  ? change_enable_ff[15:0] :
        sel_enh  ? 16'(change_enable_ff[CHANGE_INPUTS-1:16]) :
        port_b_pkg::READ_ZERO; // R14

    // Data stand for one cycle only, zero otherwise
    wire [15:0] nxt_rdata = req.rd ? rd_mux : port_b_pkg::READ_ZERO;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            rdata_ff <= port_b_pkg::READ_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_OUT = rdata_ff;

    // ==========================================================
    // Change input synchroniser
    // Two flops before the edge detector; only the second is read
    // by the clocked path.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            chg_meta_ff <= '0;
            chg_sync_ff <= '0;
        end else begin
            chg_meta_ff <= CHANGE_PIN_IN;
            chg_sync_ff <= chg_meta_ff;
        end
    end

    // Last synchronised state, for edge detection
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            chg_prev_ff <= '0;
        end else begin
            chg_prev_ff <= chg_sync_ff;
        end
    end

    // ==========================================================
    // Per-input change detection
    wire [CHANGE_INPUTS-1:0] sync_edge;
    wire [CHANGE_INPUTS-1:0] raw_mismatch;

    genvar gc;
    generate
        for (gc = 0; gc < CHANGE_INPUTS; gc++) begin : g_chg
            // Clocked edge on an enabled input
            assign sync_edge[gc]    =
                (chg_sync_ff[gc] ^ chg_prev_ff[gc]) & change_enable_ff[gc]; // R7
            // Raw pin against its last sampled state needs no clock edge
            assign raw_mismatch[gc] =
                (CHANGE_PIN_IN[gc] ^ chg_sync_ff[gc]) & change_enable_ff[gc]; // R8
        end
    endgenerate

    wire nxt_irq      = |sync_edge; // R7
    wire async_change = |raw_mismatch; // R8

    // ==========================================================
    // Change request
    // The clocked part raises the request again for one cycle, starting
    // one cycle after the synchroniser has caught up, so a short pulse is not missed.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq; // R7
        end
    end

    // A change with the clock stopped still raises the request
    assign CHANGE_IRQ_OUT = irq_ff | (async_change & ~RESET_IN); // R7

endmodule

// File: tb/port_b_assertions.sv
`timescale 1ns/100ps
module port_b_assertions #(
    parameter int PORT_BITS     = 6,
    parameter int CHANGE_INPUTS = 22
) (
    input wire logic                     CORE_CLK_IN,
    input wire logic                     RESET_IN,
    input wire logic [15:0]              REG_ADDR_IN,
    input wire logic [15:0]              REG_WDATA_IN,
    input wire logic                     REG_WR_IN,
    input wire logic                     REG_RD_IN,
    input wire logic [15:0]              REG_RDATA_OUT,
    input wire logic [PORT_BITS-1:0]     PIN_OUT,
    input wire logic [PORT_BITS-1:0]     PIN_OE_N_OUT,
    input wire logic [PORT_BITS-1:0]     ANALOG_ROUTE_OUT,
    input wire logic [PORT_BITS-1:0]     ANALOG_OWN_LEVEL_OUT,
    input wire logic [CHANGE_INPUTS-1:0] CHANGE_PIN_IN,
    input wire logic                     CHANGE_IRQ_OUT
);
    wire wr_dir  = REG_WR_IN && REG_ADDR_IN == port_b_pkg::ADDR_DIR_SELECT_B;
    wire wr_ana  = REG_WR_IN && REG_ADDR_IN == port_b_pkg::ADDR_ANALOG_SEL_CFG;
    wire wr_hold = REG_WR_IN && (REG_ADDR_IN == port_b_pkg::ADDR_OUT_HOLDING_B
                   || REG_ADDR_IN == port_b_pkg::ADDR_PIN_LEVEL_B);
    wire rd_dir  = REG_RD_IN && REG_ADDR_IN == port_b_pkg::ADDR_DIR_SELECT_B;
    wire rd_pin  = REG_RD_IN && REG_ADDR_IN == port_b_pkg::ADDR_PIN_LEVEL_B;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ==========================================================
    // Assertions
    rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 16'h0000)
        else $error("read data outside read slot");
    dir_write_a: assert property (wr_dir |=> PIN_OE_N_OUT == $past(REG_WDATA_IN[PORT_BITS-1:0]))
        else $error("direction write lost");
    hold_write_a: assert property (wr_hold |=> PIN_OUT == $past(REG_WDATA_IN[PORT_BITS-1:0]))
        else $error("holding write lost");
    route_write_a: assert property (wr_ana |=> ANALOG_ROUTE_OUT == $past(REG_WDATA_IN[PORT_BITS-1:0]))
        else $error("analog select write lost");
    dir_readback_a: assert property (rd_dir |=> REG_RDATA_OUT == 16'(PIN_OE_N_OUT))
        else $error("direction readback wrong");
    pin_analog_a: assert property (rd_pin |=> (REG_RDATA_OUT & ~16'(~ANALOG_ROUTE_OUT)) == 16'h0000)
        else $error("analog pin reads nonzero");
    own_level_a: assert property (((ANALOG_OWN_LEVEL_OUT ^ PIN_OUT) & ANALOG_ROUTE_OUT & ~PIN_OE_N_OUT) == '0)
        else $error("converter misses driven level");
    reset_val_a: assert property ($fell(RESET_IN) |-> PIN_OE_N_OUT == '1 && PIN_OUT == '0)
        else $error("port reset values wrong");
    irq_quiet_a: assert property ($stable(CHANGE_PIN_IN)[*5] |-> !CHANGE_IRQ_OUT)
        else $error("change request without change");
    cover property ($rose(CHANGE_IRQ_OUT));
    cover property (wr_ana ##[1:20] rd_pin);
    cover property (rd_dir ##1 REG_RDATA_OUT == 16'h0000);
endmodule

bind port_b_analog_change_notify port_b_assertions #(
    .PORT_BITS(PORT_BITS),
    .CHANGE_INPUTS(CHANGE_INPUTS)
) i_chk (.*);

// File: tb/pin_world.sv
`timescale 1ns/100ps
module pin_world (
    input  wire logic [5:0] level_in,
    input  wire logic [5:0] pin_out_in,
    input  wire logic [5:0] oe_n_in,
    output logic      [5:0] pad_out
);
    // Released pads follow the outside level, driven pads the port
    assign pad_out = (oe_n_in & level_in) | (~oe_n_in & pin_out_in);
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
    logic [5:0]  level = 6'h00, pad, pout, oe_n;
    logic [21:0] chg = 22'h000000;
    int          error_cnt = 0, comparisons = 0;
    always #20 clk = ~clk;
    port_b_analog_change_notify i_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .PIN_IN(pad), .PIN_OUT(pout), .PIN_OE_N_OUT(oe_n), .ANALOG_ROUTE_OUT(),
        .ANALOG_OWN_LEVEL_OUT(), .CHANGE_PIN_IN(chg), .CHANGE_IRQ_OUT(irq));
    pin_world i_pins (.level_in(level), .pin_out_in(pout), .oe_n_in(oe_n), .pad_out(pad));
    // ==========================================================
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(16'h02c6, 16'h003f);
        rd_chk(16'h02c8, 16'h0000);
        rd_chk(16'h02cb, 16'h0000);
        rd_chk(16'h0300, 16'h0000);
        $display("reset test done");
        wr_reg(16'h02c6, 16'hffc0);
        rd_chk(16'h02c6, 16'h0000);
        wr_reg(16'h02cb, 16'hff2d);
        rd_chk(16'h02cb, 16'h002d);
        repeat (3) @(posedge clk);
        rd_chk(16'h02c8, 16'h002d);
        wr_reg(16'h02c8, 16'h0012);
        rd_chk(16'h02cb, 16'h0012);
        $display("port test done");
        wr_reg(16'h02a8, 16'h0003);
        wr_reg(16'h02c6, 16'h003f);
        level <= 6'h3f;
        repeat (3) @(posedge clk);
        rd_chk(16'h02c8, 16'h003c);
        $display("analog test done");
        wr_reg(16'h02b0, 16'h0001);
        wr_reg(16'h02b2, 16'h0020);
        @(posedge clk);
        chg <= 22'h200000;
        #1 chk({15'h0000, irq}, 16'h0001);
        repeat (6) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        @(posedge clk);
        chg <= 22'h200002;
        #1 chk({15'h0000, irq}, 16'h0000);
        repeat (3) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        $display("change test done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(16'h02c6, 16'h003f);
        rd_chk(16'h02a8, 16'h0000);
        rd_chk(16'h02b2, 16'h0000);
        $display("second reset test done");
        finish_test;
    end
    initial begin
        repeat (400) @(posedge clk);
        error_cnt++;
        finish_test;
    end
endmodule
